// File: core/rnghg_top.sv
// Overview of operation
// - Total-failure check runs at start; a total failure releases no output.
// - Total failure in operation withholds all words built from later raw bits.
// - Online statistical test on raw bits at start-up and during operation.
// - Output blocked until start-up test passes and whenever a defect is flagged.
// - Raw stream quality checked continuously; defects flagged within one window.
// - Random words are delivered eight or sixteen bits wide.
// - A continuous repetition test runs on generated random words.
// - Internal random bits carry average Shannon entropy above 0.997.
`timescale 1ns/1ps
module rnghg_top
  import rnghg_pkg::*;
#(
  parameter int unsigned STARTUP_LEN = STARTUP_BITS,
  parameter int unsigned WINDOW_LEN  = ONLINE_WINDOW,
  parameter int unsigned ONES_MIN    = ONLINE_ONES_MIN,
  parameter int unsigned ONES_MAX    = ONLINE_ONES_MAX,
  parameter int unsigned RUN_LIMIT   = TOTFAIL_RUN
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        raw_bit,
  input  wire logic        raw_valid,
  input  wire logic        word_wide,
  input  wire logic        word_ready,
  output logic             word_valid,
  output logic [15:0]      word_data,
  output logic             rng_ready,
  output logic             fail_total,
  output logic             fail_online,
  output logic             fail_repeat
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [1:0] bit_sync_reg;
  logic [1:0] vld_sync_reg;
  logic       vld_d_reg;
  logic       sample;
  logic       bit_s;

  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_sync_reg <= 2'h0;
      vld_sync_reg <= 2'h0;
      vld_d_reg    <= 1'b0;
    end else begin
      bit_sync_reg <= {bit_sync_reg[0], raw_bit};
      vld_sync_reg <= {vld_sync_reg[0], raw_valid};
      vld_d_reg    <= vld_sync_reg[1];
    end
  end
  assign bit_s  = bit_sync_reg[1];
  assign sample = vld_sync_reg[1] && !vld_d_reg;

  // ------------------------------------------------------------
  // Total failure test
  // ------------------------------------------------------------
  // A stuck source shows as a long run of one value; the run limit
  // bounds how many suspect bits can reach the output.
  logic        last_bit_reg;
  logic [15:0] run_reg;
  logic        tot_hit;

  always_ff @(posedge mclk) begin
    if (reset) begin
      last_bit_reg <= 1'b0;
      run_reg      <= 16'h0000;
    end else if (sample) begin
      last_bit_reg <= bit_s;
      run_reg      <= (bit_s == last_bit_reg) ? run_reg + 16'h0001 : 16'h0001;
    end
  end
  assign tot_hit = sample && (bit_s == last_bit_reg) && (run_reg >= 16'(RUN_LIMIT - 1));

  // ------------------------------------------------------------
  // Online test: ones count per window
  // ------------------------------------------------------------
  logic [15:0] win_cnt_reg;
  logic [15:0] ones_reg;
  logic [15:0] startup_cnt_reg;
  logic        win_end;
  logic [15:0] ones_final;
  logic        online_hit;

  assign win_end    = sample && (win_cnt_reg == 16'(WINDOW_LEN - 1));
  assign ones_final = ones_reg + {15'h0000, bit_s};
  assign online_hit = win_end && ((ones_final < 16'(ONES_MIN)) ||
                                  (ones_final > 16'(ONES_MAX)));

  always_ff @(posedge mclk) begin
    if (reset) begin
      win_cnt_reg <= 16'h0000;
      ones_reg    <= 16'h0000;
    end else if (win_end) begin
      win_cnt_reg <= 16'h0000;
      ones_reg    <= 16'h0000;
    end else if (sample) begin
      win_cnt_reg <= win_cnt_reg + 16'h0001;
      ones_reg    <= ones_final;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      startup_cnt_reg <= 16'h0000;
    end else if (sample && startup_cnt_reg != 16'(STARTUP_LEN)) begin
      startup_cnt_reg <= startup_cnt_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Failure flags and state
  // ------------------------------------------------------------
  rnghg_state_e state_reg;
  logic         rep_hit;
  logic         any_hit;

  assign any_hit = tot_hit || online_hit || rep_hit;

  always_ff @(posedge mclk) begin
    if (reset) begin
      fail_total  <= 1'b0;
      fail_online <= 1'b0;
      fail_repeat <= 1'b0;
    end else begin
      if (tot_hit)    fail_total  <= 1'b1;
      if (online_hit) fail_online <= 1'b1;
      if (rep_hit)    fail_repeat <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= RNGHG_STARTUP;
    end else begin
      case (state_reg)
        RNGHG_STARTUP: begin
          if (any_hit) begin
            state_reg <= RNGHG_FAILED;
          end else if (startup_cnt_reg == 16'(STARTUP_LEN)) begin
            state_reg <= RNGHG_RUN;
          end
        end
        RNGHG_RUN: begin
          if (any_hit) begin
            state_reg <= RNGHG_FAILED;
          end
        end
        default: begin
          state_reg <= RNGHG_FAILED;
        end
      endcase
    end
  end

  logic gate_open;
  assign gate_open = (state_reg == RNGHG_RUN) && !any_hit;
  assign rng_ready = gate_open;

  // ------------------------------------------------------------
  // Word assembly and repetition test
  // ------------------------------------------------------------
  // Width is sampled when a word starts, so a change mid-word cannot
  // produce a mixed-length word.
  logic [15:0] shift_reg;
  logic [4:0]  nbits_reg;
  logic        wide_reg;
  logic        word_done;
  logic [15:0] word_next;
  logic [15:0] prev_word_reg;
  logic        prev_ok_reg;
  logic        word_out_pend_reg;
  logic [15:0] word_out_reg;

  assign word_next = {shift_reg[14:0], bit_s};
  assign word_done = sample && (nbits_reg == (wide_reg ? 5'(WORD_WIDE - 1)
                                                       : 5'(WORD_NARROW - 1)));
  assign rep_hit   = word_done && prev_ok_reg &&
                     (((wide_reg ? word_next : {8'h00, word_next[7:0]})) == prev_word_reg);

  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_reg <= WORD_RESET;
      nbits_reg <= 5'h00;
      wide_reg  <= 1'b0;
    end else if (word_done) begin
      shift_reg <= WORD_RESET;
      nbits_reg <= 5'h00;
    end else if (sample) begin
      if (nbits_reg == 5'h00) begin
        wide_reg <= word_wide;
      end
      shift_reg <= word_next;
      nbits_reg <= nbits_reg + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_word_reg <= WORD_RESET;
      prev_ok_reg   <= 1'b0;
    end else if (word_done) begin
      prev_word_reg <= wide_reg ? word_next : {8'h00, word_next[7:0]};
      prev_ok_reg   <= 1'b1;
    end
  end

  // A finished word waits one cycle so its checks resolve before release.
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_out_pend_reg <= 1'b0;
      word_out_reg      <= WORD_RESET;
    end else begin
      word_out_pend_reg <= word_done && !any_hit;
      word_out_reg      <= wide_reg ? word_next : {8'h00, word_next[7:0]};
    end
  end

  // ------------------------------------------------------------
  // Output buffer
  // ------------------------------------------------------------
  rnghg_fifo_if #(.WIDTH(WORD_WIDE)) fifo_bus ();

  assign fifo_bus.in_valid  = word_out_pend_reg && gate_open;
  assign fifo_bus.in_data   = word_out_reg;
  assign fifo_bus.out_ready = word_ready && gate_open;
  assign fifo_bus.flush     = (state_reg != RNGHG_RUN) || any_hit;

  rnghg_fifo #(
    .WIDTH (WORD_WIDE),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk  (mclk),
    .reset (reset),
    .port  (fifo_bus.fifo)
  );

  // The word is dropped while the buffer is full; a random source loses
  // nothing of value by skipping a word, and stalling it is impossible.
  assign word_valid = fifo_bus.out_valid && gate_open;
  assign word_data  = fifo_bus.out_data;

endmodule : rnghg_top

// File: core/rnghg_pkg.sv
package rnghg_pkg;

  // Start-up test length in raw bits.
  localparam int unsigned STARTUP_BITS      = 1024;
  // Total failure: this many identical raw bits in a row.
  localparam int unsigned TOTFAIL_RUN       = 32;
  // Online test window and tolerated count of ones.
  localparam int unsigned ONLINE_WINDOW     = 256;
  localparam int unsigned ONLINE_ONES_MIN   = 96;
  localparam int unsigned ONLINE_ONES_MAX   = 160;
  // Widths of the two output formats.
  localparam int unsigned WORD_NARROW       = 8;
  localparam int unsigned WORD_WIDE         = 16;
  localparam int unsigned FIFO_DEPTH        = 4;
  localparam logic [15:0] WORD_RESET        = 16'h0000;

  typedef enum logic [1:0] {
    RNGHG_STARTUP,
    RNGHG_RUN,
    RNGHG_FAILED
  } rnghg_state_e;

endpackage : rnghg_pkg

// File: core/rnghg_fifo_if.sv
`timescale 1ns/1ps
interface rnghg_fifo_if #(
  parameter int WIDTH = 16
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic             flush;

  modport fifo (
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data,
    input  flush
  );
  modport user (
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data,
    output flush
  );
endinterface : rnghg_fifo_if

// File: core/rnghg_fifo.sv
`timescale 1ns/1ps
module rnghg_fifo
  import rnghg_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic        mclk,
  input wire logic        reset,
  rnghg_fifo_if.fifo      port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign port.in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign port.out_valid = (count_reg != '0);
  assign port.out_data  = mem_reg[rd_ptr_reg];
  assign push = port.in_valid && port.in_ready;
  assign pop  = port.out_valid && port.out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= port.in_data;
    end
  end

  // Flush discards held words so nothing made before a failure leaks out.
  always_ff @(posedge mclk) begin
    if (reset || port.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : rnghg_fifo

// File: verif/rnghg_assertions.sv
`timescale 1ns/1ps
module rnghg_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic word_valid,
  input wire logic rng_ready,
  input wire logic fail_total,
  input wire logic fail_online,
  input wire logic fail_repeat
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  gate_open_a: assert property (word_valid |-> rng_ready)
    else $error("word offered while output gate closed");
  fill_gate_a: assert property ($rose(word_valid) |-> $past(rng_ready))
    else $error("word entered buffer while output gate closed");
  total_block_a: assert property (fail_total |-> !word_valid && !rng_ready)
    else $error("output open after source failure");
  online_block_a: assert property (fail_online |-> !word_valid && !rng_ready)
    else $error("output open after statistical defect");
  repeat_block_a: assert property (fail_repeat |-> !word_valid && !rng_ready)
    else $error("output open after repeated word");
  total_keep_a: assert property (fail_total |=> fail_total)
    else $error("source failure flag cleared without reset");
  online_keep_a: assert property (fail_online |=> fail_online)
    else $error("defect flag cleared without reset");
  repeat_keep_a: assert property (fail_repeat |=> fail_repeat)
    else $error("repeat flag cleared without reset");
  start_quiet_a: assert property ($fell(reset) |->
    (!rng_ready && !fail_total && !fail_online && !fail_repeat) [*8])
    else $error("gate or flag active right after reset");
endmodule : rnghg_assertions

bind rnghg_top rnghg_assertions rnghg_assertions_i (.mclk, .reset, .word_valid, .rng_ready,
  .fail_total, .fail_online, .fail_repeat);

// File: verif/rnghg_consumer.sv
`timescale 1ns/1ps
module rnghg_consumer (
  input  wire logic mclk,
  input  wire logic stall,
  output logic      word_ready
);
  // Readiness is random so the buffer sees both prompt and slow takers.
  initial word_ready = 1'b0;
  always @(negedge mclk) word_ready <= !stall && ($urandom % 4 != 0);
endmodule : rnghg_consumer

// File: verif/rng_health_gated_output_tb_top.sv
`timescale 1ns/1ps
module rng_health_gated_output_tb_top import rnghg_pkg::*;;
  logic        mclk = 1'b0, reset = 1'b1, raw_bit = 1'b0, raw_valid = 1'b0;
  logic        word_wide = 1'b0, stall = 1'b0, word_ready, word_valid, rng_ready;
  logic        fail_total, fail_online, fail_repeat;
  logic [15:0] word_data, prev = 16'h0;
  logic [15:0] exp_q[$];
  int          err_total = 0, n_compared = 0;

  always #10 mclk = ~mclk;

  rnghg_top #(.STARTUP_LEN(64), .WINDOW_LEN(32), .ONES_MIN(8), .ONES_MAX(24), .RUN_LIMIT(8))
    rnghg_top_i (.mclk, .reset, .raw_bit, .raw_valid, .word_wide, .word_ready, .word_valid,
    .word_data, .rng_ready, .fail_total, .fail_online, .fail_repeat);
  rnghg_consumer rnghg_consumer_i (.mclk, .stall, .word_ready);

  task finish_test;
    $display("mismatches %0d of %0d compared", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_flag(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask : chk_flag

  // A word with nothing left to expect is reported as an unwanted valid.
  always @(posedge mclk) begin
    if (!reset && word_valid === 1'b1 && word_ready === 1'b1) begin
      if (exp_q.size() != 0) chk_word(word_data, exp_q.pop_front());
      else chk_flag(word_valid, 1'b0);
    end
  end

  task send_bit(input logic b);
    raw_bit <= b;
    raw_valid <= 1'b1;
    repeat (2) @(negedge mclk);
    raw_valid <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask : send_bit

  // Each raw pair is 10 or 01, so every window holds half ones and no long runs.
  task send_word(input logic w, input bit keep, input bit rep);
    logic [15:0] v;
    int          n;
    n = w ? WORD_WIDE : WORD_NARROW;
    v = prev;
    while (!rep && v == prev) begin
      v = 16'h0;
      for (int i = 0; i < n; i += 2) v = (v << 2) | ($urandom % 2 ? 16'h2 : 16'h1);
    end
    prev = v;
    word_wide <= w;
    if (keep) exp_q.push_back(v);
    for (int i = n - 1; i >= 0; i--) send_bit(v[i]);
  endtask : send_word

  task drain;
    for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(negedge mclk);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("[FAIL] %0t words left %h exp %h", $time, exp_q.size(), 0);
      finish_test;
    end
  endtask : drain

  task do_reset;
    reset <= 1'b1;
    stall <= 1'b0;
    exp_q.delete();
    repeat (4) @(negedge mclk);
    reset <= 1'b0;
  endtask : do_reset

  task startup;
    repeat (4) send_word(1'b1, 0, 0);
    repeat (4) @(negedge mclk);
  endtask : startup

  initial begin
    void'($urandom(32'h21bdd842));
    repeat (4) @(negedge mclk);
    reset <= 1'b0;
    startup;
    chk_flag(rng_ready, 1'b1);
    repeat (30) send_word(1'($urandom % 2), 1, 0);
    drain;
    stall <= 1'b1;
    repeat (6) send_word(1'b0, exp_q.size() < FIFO_DEPTH, 0);
    stall <= 1'b0;
    drain;
    stall <= 1'b1;
    word_wide <= 1'b1;
    for (int i = 0; i < 16; i++) send_bit(1'b0);
    chk_flag(fail_total, 1'b1);
    chk_flag(rng_ready, 1'b0);
    stall <= 1'b0;
    repeat (2) send_word(1'b0, 0, 0);
    chk_flag(fail_total, 1'b1);
    do_reset;
    chk_flag(fail_total, 1'b0);
    for (int i = 0; i < 8; i++) send_bit(1'b1);
    repeat (4) @(negedge mclk);
    chk_flag(fail_total, 1'b1);
    startup;
    chk_flag(rng_ready, 1'b0);
    for (int ph = 0; ph < 2; ph++) begin
      do_reset;
      if (ph != 0) startup;
      stall <= 1'b1;
      // Phase 0 starves the window of ones, phase 1 floods it.
      for (int i = 0; i < 64; i++) send_bit((i % 7 == 0) ^ (ph != 0));
      chk_flag(fail_online, 1'b1);
      chk_flag(fail_total, 1'b0);
      stall <= 1'b0;
      repeat (8) @(negedge mclk);
    end
    do_reset;
    startup;
    send_word(1'b0, 1, 0);
    drain;
    stall <= 1'b1;
    send_word(1'b0, 0, 1);
    repeat (4) @(negedge mclk);
    chk_flag(fail_repeat, 1'b1);
    stall <= 1'b0;
    repeat (8) @(negedge mclk);
    chk_flag(fail_repeat, 1'b1);
    finish_test;
  end
endmodule : rng_health_gated_output_tb_top
